/* common/clk_gen_pkg.sv */
// Package with constants for the system clock generation block
package clk_gen_pkg;
   // Register byte offsets
   localparam logic [3:0] CTRL_OFS    = 4'h0;  // Clock source control
   localparam logic [3:0] STATUS_OFS  = 4'h4;  // Mode and clock status
   localparam logic [3:0] SSIDIV_OFS  = 4'h8;  // Sync serial divider select
   // Control field positions
   localparam int T0_EXT_BIT    = 0;  // Timer 0 counts its input pin
   localparam int T1_EXT_BIT    = 1;  // Timer 1 counts its input pin
   localparam int UART_EXT_BIT  = 2;  // UART uses external clock
   // Reset values
   localparam logic [2:0] CTRL_RST   = 3'h0;
   localparam logic [2:0] SSIDIV_RST = 3'h0;  // Divide by 2
   // Quarter-rate prescale width
   localparam int QTR_W = 2;
   // Mode decode of the two straps
   typedef enum logic [1:0] {
      MODE_BYPASS = 2'h0,
      MODE_X1     = 2'h1,
      MODE_X2     = 2'h3,
      MODE_X4     = 2'h2
   } pll_mode_e;
   // Strap pair to mode
   function automatic pll_mode_e strap_to_mode(input logic [1:0] s);
      unique case (s)
         2'h0: strap_to_mode = MODE_BYPASS;
         2'h1: strap_to_mode = MODE_X1;
         2'h2: strap_to_mode = MODE_X2;
         2'h3: strap_to_mode = MODE_X4;
      endcase
   endfunction
endpackage

/* hw/pin_sync.sv */
// Two-flop synchroniser bank for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         sys_rst_in,
   // Pins and synchronised copies
   input  wire logic [W-1:0] pins_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;  // First stage, read only by second stage
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_d;
   // Next values
   always_comb begin
      meta_d = pins_in;
      sync_d = meta_q;
   end
   // Stage registers
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= meta_d;
         sync_out <= sync_d;
      end
   end
endmodule
`default_nettype wire

/* hw/system_clock_generation.sv */
// System clock generation: mode straps, dividers, timer and UART clock selection
//
// Contract
// [R1] System clock is reference times one, two, four
// [R2] Two straps choose mode during reset
// [R3] Bypass uses reference clock directly
// [R4] HDLC clocks come straight from pins; code passes them through two sync flops and a register
// [R5] Partner keeps HDLC clocks below system clock
// [R6] HDLC clocks supported up to 10 MHz
// [R7] Serial clock is system clock over 2..256
// [R8] Timers 0,1 count pin or quarter clock
// [R9] Timer 2 always counts quarter clock
// [R10] UART clock is system or external pin
// [R11] Bypass output frequency equals oscillator input
// [R12] Straps latched at reset release, held after
`timescale 1ns/1ps
`default_nettype none
module system_clock_generation
   import clk_gen_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   // Mode straps
   input  wire logic        pll_mode_strap_a,
   input  wire logic        pll_mode_strap_b,
   // External clock-like pins
   input  wire logic        timer_input_pin_0,
   input  wire logic        timer_input_pin_1,
   input  wire logic        uart_ext_clock,
   input  wire logic [1:0]  hdlc_tx_clock_pin,
   input  wire logic [1:0]  hdlc_rx_clock_pin,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Derived clock enables and selections
   output logic      [1:0]  pll_mult_out,
   output logic             pll_bypass_out,
   output logic             sync_serial_iface_clk_out,
   output logic      [2:0]  timer_tick_out,
   output logic             uart_clk_tick_out,
   output logic      [1:0]  hdlc_tx_clk_out,
   output logic      [1:0]  hdlc_rx_clk_out
);
   // Synchronised pins
   logic [6:0] pins_s;
   logic       strap_a_s;
   logic       strap_b_s;
   logic       tmr0_s;
   logic       tmr1_s;
   logic       uart_ext_clock_s;
   logic [1:0] htx_s;
   logic [1:0] hrx_s;

   // All outside pins pass two flops first
   pin_sync #(.W(7)) u_sync (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .pins_in    ({pll_mode_strap_a, pll_mode_strap_b, timer_input_pin_0,
                    timer_input_pin_1, uart_ext_clock, hdlc_tx_clock_pin[0],
                    hdlc_rx_clock_pin[0]}),
      .sync_out   (pins_s)
   );
   // Second HDLC channel synchroniser
   logic [1:0] hch1_s;
   pin_sync #(.W(2)) u_sync_h1 (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .pins_in    ({hdlc_tx_clock_pin[1], hdlc_rx_clock_pin[1]}),
      .sync_out   (hch1_s)
   );
   assign strap_a_s = pins_s[6];
   assign strap_b_s = pins_s[5];
   assign tmr0_s    = pins_s[4];
   assign tmr1_s    = pins_s[3];
   assign uart_ext_clock_s    = pins_s[2];
   assign htx_s     = {hch1_s[1], pins_s[1]};
   assign hrx_s     = {hch1_s[0], pins_s[0]};

   // Mode latch state
   pll_mode_e  mode_q, mode_d;     // Held PLL mode
   logic [2:0] rst_seen_q, rst_seen_d;  // Marker walks to bit 0 as synced straps settle
   logic       bypass_q, bypass_d;
   logic [1:0] mult_q, mult_d;

   // Latch mode once, after the synchroniser holds the release-time straps
   always_comb begin
      mode_d     = mode_q;
      rst_seen_d = {1'b0, rst_seen_q[2:1]};
      // Synchroniser is cleared in reset, so wait out its two stages
      if (rst_seen_q[0]) begin
         mode_d = strap_to_mode({strap_b_s, strap_a_s});  // R2 R12
      end
      bypass_d = (mode_d == MODE_BYPASS);  // R3 R11
      unique case (mode_d)
         MODE_X2: mult_d = 2'h1;  // R1
         MODE_X4: mult_d = 2'h2;  // R1
         default: mult_d = 2'h0;  // Times one, or bypass
      endcase
   end

   // Mode registers
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         mode_q     <= MODE_BYPASS;
         rst_seen_q <= 3'h4;
         bypass_q   <= 1'b1;
         mult_q     <= 2'h0;
      end else begin
         mode_q     <= mode_d;
         rst_seen_q <= rst_seen_d;
         bypass_q   <= bypass_d;
         mult_q     <= mult_d;
      end
   end

   // Software state
   logic [2:0] ctrl_q, ctrl_d;     // Source selections
   logic [2:0] ssidiv_q, ssidiv_d; // Divider exponent minus one
   logic [7:0] ssicnt_q, ssicnt_d; // Serial clock divider counter
   logic       ssiclk_q, ssiclk_d;
   logic [QTR_W-1:0] qcnt_q, qcnt_d;  // Quarter-rate prescaler
   logic [2:0] ttick_q, ttick_d;
   logic       uart_ext_clock_prev_q, uart_ext_clock_prev_d;
   logic       uart_q, uart_d;
   logic [1:0] t_prev_q, t_prev_d;
   logic [1:0] htx_q, htx_d;
   logic [1:0] hrx_q, hrx_d;
   logic [31:0] rdata_q, rdata_d;
   logic       wait_q, wait_d;
   logic       qtick;
   logic [7:0] half_period;

   // Bus, dividers and clock selection
   always_comb begin
      ctrl_d   = ctrl_q;
      ssidiv_d = ssidiv_q;
      rdata_d  = rdata_q;
      // One wait cycle then answer
      wait_d   = 1'b1;
      if ((avs_read || avs_write) && wait_q) begin
         wait_d = 1'b0;
         // Read data prepared now, stands when waitrequest drops
         if (avs_read) begin
            unique case (avs_address)
               CTRL_OFS:   rdata_d = {29'h0, ctrl_q};
               SSIDIV_OFS: rdata_d = {29'h0, ssidiv_q};
               STATUS_OFS: rdata_d = {27'h0, bypass_q, mult_q, mode_q};
               default:    rdata_d = 32'h0;  // Unmapped reads zero
            endcase
         end
      end
      // Write lands only at the edge where waitrequest is seen low
      if (avs_write && !wait_q) begin
         unique case (avs_address)
            CTRL_OFS:   ctrl_d   = avs_writedata[2:0];
            SSIDIV_OFS: ssidiv_d = avs_writedata[2:0];
            default:    ;  // Unmapped writes ignored
         endcase
      end
      // Serial clock: toggle every 2^k cycles gives divide by 2^(k+1)
      half_period = 8'(8'h1 << ssidiv_q);
      ssicnt_d    = ssicnt_q + 8'h1;
      ssiclk_d    = ssiclk_q;
      if (ssicnt_q + 8'h1 >= half_period) begin
         ssicnt_d = 8'h0;
         ssiclk_d = ~ssiclk_q;  // R7
      end
      // Quarter-rate tick
      qcnt_d  = qcnt_q + 2'h1;
      qtick   = (qcnt_q == 2'h3);
      t_prev_d = {tmr1_s, tmr0_s};
      ttick_d[0] = ctrl_q[T0_EXT_BIT] ? (tmr0_s & ~t_prev_q[0]) : qtick;  // R8
      ttick_d[1] = ctrl_q[T1_EXT_BIT] ? (tmr1_s & ~t_prev_q[1]) : qtick;  // R8
      ttick_d[2] = qtick;  // R9
      // UART source: system clock every cycle or external rising edge
      uart_ext_clock_prev_d = uart_ext_clock_s;
      uart_d = ctrl_q[UART_EXT_BIT] ? (uart_ext_clock_s & ~uart_ext_clock_prev_q) : 1'b1;  // R10
      // HDLC clocks pass from pins through the two-flop synchroniser and one output register
      htx_d = htx_s;  // R4 R5 R6
      hrx_d = hrx_s;  // R4
   end

   // Registers of the control path
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ctrl_q      <= CTRL_RST;
         ssidiv_q    <= SSIDIV_RST;
         ssicnt_q    <= 8'h0;
         ssiclk_q    <= 1'b0;
         qcnt_q      <= '0;
         ttick_q     <= 3'h0;
         uart_ext_clock_prev_q <= 1'b0;
         uart_q      <= 1'b0;
         t_prev_q    <= 2'h0;
         htx_q       <= 2'h0;
         hrx_q       <= 2'h0;
         rdata_q     <= 32'h0;
         wait_q      <= 1'b1;
      end else begin
         ctrl_q      <= ctrl_d;
         ssidiv_q    <= ssidiv_d;
         ssicnt_q    <= ssicnt_d;
         ssiclk_q    <= ssiclk_d;
         qcnt_q      <= qcnt_d;
         ttick_q     <= ttick_d;
         uart_ext_clock_prev_q <= uart_ext_clock_prev_d;
         uart_q      <= uart_d;
         t_prev_q    <= t_prev_d;
         htx_q       <= htx_d;
         hrx_q       <= hrx_d;
         rdata_q     <= rdata_d;
         wait_q      <= wait_d;
      end
   end

   // Outputs straight from flops
   assign avs_readdata              = rdata_q;
   assign avs_waitrequest           = wait_q;
   assign pll_mult_out              = mult_q;
   assign pll_bypass_out            = bypass_q;
   assign sync_serial_iface_clk_out = ssiclk_q;
   assign timer_tick_out            = ttick_q;
   assign uart_clk_tick_out         = uart_q;
   assign hdlc_tx_clk_out           = htx_q;
   assign hdlc_rx_clk_out           = hrx_q;
endmodule
`default_nettype wire

/* testbench/clk_gen_chk_sva.sv */
// Checker for the system clock generation block
`timescale 1ns/1ps
`default_nettype none
module clk_gen_chk
   import clk_gen_pkg::*;
(
   // Clock, reset and bus
   input wire logic        clk_in,
   input wire logic        sys_rst_in,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   // Pins and derived outputs
   input wire logic [1:0]  hdlc_tx_clock_pin,
   input wire logic [1:0]  hdlc_rx_clock_pin,
   input wire logic [1:0]  hdlc_tx_clk_out,
   input wire logic [1:0]  hdlc_rx_clk_out,
   input wire logic [2:0]  timer_tick_out,
   input wire logic        uart_clk_tick_out,
   input wire logic [1:0]  pll_mult_out,
   input wire logic        pll_bypass_out,
   input wire logic        sync_serial_iface_clk_out
);
   logic [2:0] up_q;    // Cycles since reset, saturating
   logic [2:0] ctrl_q;  // Shadow of source control
   logic [2:0] div_q;   // Shadow of divider select
   wire logic  ok = up_q == 3'h7;                // Pipelines flushed
   wire logic  wr = avs_write && !avs_waitrequest;  // Write takes effect
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // Reset age and register shadows
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         up_q   <= 3'h0;
         ctrl_q <= CTRL_RST;
         div_q  <= SSIDIV_RST;
      end else begin
         up_q <= up_q + {2'h0, !ok};
         if (wr && avs_address == CTRL_OFS) ctrl_q <= avs_writedata[2:0];
         if (wr && avs_address == SSIDIV_OFS) div_q <= avs_writedata[2:0];
      end
   end
   a_hdlc_tx: assert property (ok |-> hdlc_tx_clk_out == $past(hdlc_tx_clock_pin, 3))
      else $error("hdlc tx clock path wrong");
   a_hdlc_rx: assert property (ok |-> hdlc_rx_clk_out == $past(hdlc_rx_clock_pin, 3))
      else $error("hdlc rx clock path wrong");
   a_t2_quarter: assert property (timer_tick_out[2] |=> !timer_tick_out[2] [*3] ##1 timer_tick_out[2])
      else $error("timer 2 tick not quarter rate");
   a_t0_internal: assert property (!ctrl_q[0] && timer_tick_out[0] |=> !timer_tick_out[0] [*3])
      else $error("timer 0 internal tick too fast");
   a_uart_internal: assert property ((ok && !ctrl_q[2]) [*4] |-> uart_clk_tick_out)
      else $error("uart internal clock missing");
   a_mode_held: assert property (ok |-> $stable(pll_mult_out) && $stable(pll_bypass_out))
      else $error("pll mode changed after reset");
   a_mode_legal: assert property (pll_mult_out != 2'h3 && !(pll_bypass_out && pll_mult_out != 2'h0))
      else $error("illegal pll mode outputs");
   a_ssi_half: assert property ((ok && div_q == 3'h0) [*2] |-> $changed(sync_serial_iface_clk_out))
      else $error("serial clock not half rate");
   c_bypass: cover property (ok && pll_bypass_out);
   c_x4: cover property (pll_mult_out == 2'h2);
   c_ext: cover property (ctrl_q[0] && timer_tick_out[0]);
endmodule
bind system_clock_generation clk_gen_chk clk_gen_chk_inst (
   .clk_in                    (clk_in),
   .sys_rst_in                (sys_rst_in),
   .avs_address               (avs_address),
   .avs_write                 (avs_write),
   .avs_writedata             (avs_writedata),
   .avs_waitrequest           (avs_waitrequest),
   .hdlc_tx_clock_pin         (hdlc_tx_clock_pin),
   .hdlc_rx_clock_pin         (hdlc_rx_clock_pin),
   .hdlc_tx_clk_out           (hdlc_tx_clk_out),
   .hdlc_rx_clk_out           (hdlc_rx_clk_out),
   .timer_tick_out            (timer_tick_out),
   .uart_clk_tick_out         (uart_clk_tick_out),
   .pll_mult_out              (pll_mult_out),
   .pll_bypass_out            (pll_bypass_out),
   .sync_serial_iface_clk_out (sync_serial_iface_clk_out)
);
`default_nettype wire

/* testbench/test_system_clock_generation.sv */
// Self-checking bench for the system clock generation block
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_generation
   import clk_gen_pkg::*;
;
   logic clk_in, sys_rst_in, pll_mode_strap_a, pll_mode_strap_b, uart_ext_clock;
   logic timer_input_pin_0, timer_input_pin_1, avs_read, avs_write, avs_waitrequest;
   logic pll_bypass_out, sync_serial_iface_clk_out, uart_clk_tick_out;
   logic [1:0] hdlc_tx_clock_pin, hdlc_rx_clock_pin, hdlc_tx_clk_out, hdlc_rx_clk_out;
   logic [1:0] pll_mult_out;
   logic [2:0] timer_tick_out;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   int bad_count, samples_checked, cyc, tk[4];
   // Status per strap code {b,a}: bypass, x1, x2, x4
   localparam logic [31:0] MT[4] = '{32'h10, 32'h01, 32'h07, 32'h0A};
   system_clock_generation system_clock_generation_inst (
      .clk_in                    (clk_in),
      .sys_rst_in                (sys_rst_in),
      .pll_mode_strap_a          (pll_mode_strap_a),
      .pll_mode_strap_b          (pll_mode_strap_b),
      .timer_input_pin_0         (timer_input_pin_0),
      .timer_input_pin_1         (timer_input_pin_1),
      .uart_ext_clock            (uart_ext_clock),
      .hdlc_tx_clock_pin         (hdlc_tx_clock_pin),
      .hdlc_rx_clock_pin         (hdlc_rx_clock_pin),
      .avs_address               (avs_address),
      .avs_read                  (avs_read),
      .avs_write                 (avs_write),
      .avs_writedata             (avs_writedata),
      .avs_readdata              (avs_readdata),
      .avs_waitrequest           (avs_waitrequest),
      .pll_mult_out              (pll_mult_out),
      .pll_bypass_out            (pll_bypass_out),
      .sync_serial_iface_clk_out (sync_serial_iface_clk_out),
      .timer_tick_out            (timer_tick_out),
      .uart_clk_tick_out         (uart_clk_tick_out),
      .hdlc_tx_clk_out           (hdlc_tx_clk_out),
      .hdlc_rx_clk_out           (hdlc_rx_clk_out)
   );
   // 40 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   // Verdict and stop
   task automatic end_sim;
      $display("checked %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Compare one value
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   // One bus access, held until waitrequest low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) begin
         bad_count++;
         end_sim();
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_in);
   endtask
   // Wait for a serial clock level, counting cycles
   task automatic wt(input logic v);
      int n;
      n = 0;
      while (sync_serial_iface_clk_out !== v) begin
         @(posedge clk_in);
         cyc++;
         n++;
         if (n > 600) begin
            bad_count++;
            end_sim();
         end
      end
   endtask
   // Count ticks; pins pulse three times when ext, hdlc pins at 10 MHz
   task automatic run(input logic ext);
      tk = '{0, 0, 0, 0};
      for (int i = 0; i < 40; i++) begin
         {timer_input_pin_0, timer_input_pin_1, uart_ext_clock} <= {3{ext & i[2] & (i < 24)}};
         hdlc_tx_clock_pin <= {2{i[1]}};
         hdlc_rx_clock_pin <= {2{~i[1]}};
         @(posedge clk_in);
         for (int j = 0; j < 3; j++) tk[j] += int'(timer_tick_out[j]);
         tk[3] += int'(uart_clk_tick_out);
      end
   endtask
   // Register reset values, masking, unmapped place
   task automatic regs;
      bus(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl_reset", 32'(CTRL_RST), q);
      bus(1'b1, CTRL_OFS, 32'hFFFFFFFF);
      bus(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl", 32'h7, q);
      bus(1'b1, 4'hC, 32'h5);
      bus(1'b0, 4'hC, 32'h0);
      chk("unmapped", 32'h0, q);
      bus(1'b0, SSIDIV_OFS, 32'h0);
      chk("ssidiv_reset", 32'(SSIDIV_RST), q);
   endtask
   // Timer and UART sources, internal then external
   task automatic timers;
      bus(1'b1, CTRL_OFS, 32'h0);
      run(1'b0);
      chk("ticks_int", 32'h0A0A0A28, {8'(tk[0]), 8'(tk[1]), 8'(tk[2]), 8'(tk[3])});
      bus(1'b1, CTRL_OFS, 32'h7);
      run(1'b1);
      chk("ticks_ext", 32'h03030A03, {8'(tk[0]), 8'(tk[1]), 8'(tk[2]), 8'(tk[3])});
   endtask
   // HDLC clocks follow their pins
   task automatic hdlc;
      for (int i = 0; i < 4; i++) begin
         hdlc_tx_clock_pin <= i[1:0];
         hdlc_rx_clock_pin <= ~i[1:0];
         repeat (4) @(posedge clk_in);
         chk("hdlc", {28'h0, i[1:0], ~i[1:0]}, {28'h0, hdlc_tx_clk_out, hdlc_rx_clk_out});
      end
   endtask
   // Serial clock period for every divider choice
   task automatic sync_serial_iface;
      int p;
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, SSIDIV_OFS, 32'(k));
         wt(1'b0);
         wt(1'b1);
         p = cyc;
         wt(1'b0);
         wt(1'b1);
         chk("ssi_period", 32'(2 << k), 32'(cyc - p));
      end
   endtask
   // Strap mode taken at reset, kept when straps move
   task automatic modes(input int s);
      {pll_mode_strap_b, pll_mode_strap_a} <= s[1:0];
      sys_rst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      {pll_mode_strap_b, pll_mode_strap_a} <= ~s[1:0];
      repeat (4) @(posedge clk_in);
      bus(1'b0, STATUS_OFS, 32'h0);
      chk("status", MT[s], q);
      chk("pll_out", {29'h0, MT[s][4:2]}, {29'h0, pll_bypass_out, pll_mult_out});
   endtask
   // Main sequence
   initial begin
      sys_rst_in = 1'b1;
      {pll_mode_strap_a, pll_mode_strap_b, uart_ext_clock, avs_read, avs_write} = 5'h00;
      {timer_input_pin_0, timer_input_pin_1, hdlc_tx_clock_pin, hdlc_rx_clock_pin} = 6'h00;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      regs();
      timers();
      hdlc();
      sync_serial_iface();
      for (int s = 0; s < 4; s++) modes(s);
      end_sim();
   end
endmodule
`default_nettype wire
